/* File: common/ppsl_map.vh */
// Constants for the output pin routing matrix and its lock.
// Assumes one 100 MHz clock and a power-on reset as the only async reset.
//
// Summary of operation
// - Every pin owns its own output selector
// - Codes 0x00-0x17: latch, waveform, capture, pulse
// - Same code set offered on every pin
// - Direction bit normally owns output driver
// - Self-driving peripherals override the direction bit
// - Lock set freezes all selector writes
// - Key 55h then AAh precedes lock change
// - Only bit set/clear or device reset changes lock bit
// - One-way option: one clear, one set
// - Sleep leaves all selections untouched
// - Power-on reset restores defaults, drops one-way
// - Input selector: port bits 4:3, pin 2:0
// - Port read returns real pin level
`ifndef PPSL_MAP_VH
`define PPSL_MAP_VH

`define PPSL_NPINS 40
`define PPSL_NSRC 24
`define PPSL_NINSEL 30
`define PPSL_SEL_W 5

`define PPSL_SRC_LATCH 5'h00
`define PPSL_SRC_LAST 5'h17
`define PPSL_OUTSEL_RESET 5'h00

`define PPSL_IN_PORT_HI 4
`define PPSL_IN_PORT_LO 3
`define PPSL_IN_PIN_HI 2
`define PPSL_IN_PIN_LO 0

`define PPSL_KEY_FIRST 8'h55
`define PPSL_KEY_SECOND 8'haa
`define PPSL_LOCK_RESET 1'b0

// Input selector defaults, as port*8+pin
`define PPSL_IN_DEF_0 5'h08
`define PPSL_IN_DEF_1 5'h09
`define PPSL_IN_DEF_2 5'h0a
`define PPSL_IN_DEF_3 5'h04
`define PPSL_IN_DEF_4 5'h10
`define PPSL_IN_DEF_5 5'h0d
`define PPSL_IN_DEF_6 5'h10
`define PPSL_IN_DEF_7 5'h10
`define PPSL_IN_DEF_8 5'h12
`define PPSL_IN_DEF_9 5'h0c
`define PPSL_IN_DEF_10 5'h13
`define PPSL_IN_DEF_11 5'h15
`define PPSL_IN_DEF_12 5'h0f
`define PPSL_IN_DEF_13 5'h0c
`define PPSL_IN_DEF_14 5'h12
`define PPSL_IN_DEF_15 5'h11
`define PPSL_IN_DEF_16 5'h08
`define PPSL_IN_DEF_17 5'h03
`define PPSL_IN_DEF_18 5'h04
`define PPSL_IN_DEF_19 5'h05
`define PPSL_IN_DEF_20 5'h17
`define PPSL_IN_DEF_21 5'h16
`define PPSL_IN_DEF_22 5'h0f
`define PPSL_IN_DEF_23 5'h0e
`define PPSL_IN_DEF_24 5'h13
`define PPSL_IN_DEF_25 5'h14
`define PPSL_IN_DEF_26 5'h05
`define PPSL_IN_DEF_27 5'h09
`define PPSL_IN_DEF_28 5'h0a
`define PPSL_IN_DEF_29 5'h08

`endif

/* File: rtl/ppsl_out_mux.v */
// One pin's output source mux with driver-enable selection.
// Assumes all sources and controls are synchronous to clk.
`timescale 1ns/1ps
`include "ppsl_map.vh"

module ppsl_out_mux (
    input wire clk,
    input wire rstn,
    input wire [`PPSL_SEL_W-1:0] sel,
    input wire latchBit,
    input wire dirIsInput,
    input wire [`PPSL_NSRC-1:0] src,
    input wire [`PPSL_NSRC-1:0] ownsDriver,
    input wire [`PPSL_NSRC-1:0] driveEn,
    output reg pinOut,
    output reg pinOe
);

    wire [`PPSL_SEL_W-1:0] srcIdx;
    wire useLatch;
    reg next_pinOut;
    reg next_pinOe;

    assign srcIdx = sel - 5'h01;
    assign useLatch = (sel == `PPSL_SRC_LATCH) || (sel > `PPSL_SRC_LAST);

    always @* begin
        next_pinOut = latchBit;
        next_pinOe = ~dirIsInput;
        if (!useLatch) begin
            next_pinOut = src[srcIdx];
            if (ownsDriver[srcIdx]) begin
                next_pinOe = driveEn[srcIdx];
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            pinOut <= next_pinOut;
            pinOe <= next_pinOe;
        end
    end

endmodule

/* File: rtl/ppsl_lock.v */
// Routing lock bit with unlock key and one-way option.
// Assumes the access strobes are one-cycle pulses, at most one per cycle.
`timescale 1ns/1ps
`include "ppsl_map.vh"

module ppsl_lock (
    input wire clk,
    input wire rstn,
    input wire deviceResetPulse,
    input wire oneWayCfg,
    input wire lockByteWrite,
    input wire [7:0] lockData,
    input wire lockBitSet,
    input wire lockBitClear,
    input wire otherAccess,
    output reg routingLockedFlag
);

    localparam KEY_IDLE = 2'd0;
    localparam KEY_HALF = 2'd1;
    localparam KEY_ARMED = 2'd2;

    reg [1:0] keyState;
    reg usedSet;
    reg usedClear;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            routingLockedFlag <= `PPSL_LOCK_RESET;
            keyState <= KEY_IDLE;
            usedSet <= 1'b0;
            usedClear <= 1'b0;
        end else if (deviceResetPulse) begin
            routingLockedFlag <= `PPSL_LOCK_RESET;
            keyState <= KEY_IDLE;
            usedSet <= 1'b0;
            usedClear <= 1'b0;
        end else if (lockByteWrite) begin
            if (lockData == `PPSL_KEY_FIRST) begin
                keyState <= KEY_HALF;
            end else if (keyState == KEY_HALF && lockData == `PPSL_KEY_SECOND) begin
                keyState <= KEY_ARMED;
            end else begin
                keyState <= KEY_IDLE;
            end
        end else if (lockBitSet || lockBitClear) begin
            keyState <= KEY_IDLE;
            case (keyState)
                KEY_ARMED: begin
                    if (lockBitSet && !(oneWayCfg && usedSet)) begin
                        routingLockedFlag <= 1'b1;
                        usedSet <= 1'b1;
                    end else if (lockBitClear && !(oneWayCfg && usedClear)) begin
                        routingLockedFlag <= 1'b0;
                        usedClear <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (otherAccess) begin
            keyState <= KEY_IDLE;
        end
    end

endmodule

/* File: rtl/ppsl_top.v */
// Output pin routing matrix, input routing and the routing lock.
// Assumes a single clk domain; pins are asynchronous and synchronised here.
// Sleep has no port: selectors only change on accepted writes.
`timescale 1ns/1ps
`include "ppsl_map.vh"

module ppsl_top (
    input wire clk,
    input wire rstn,
    input wire deviceResetPulse,
    input wire oneWayCfg,
    input wire outSelWrite,
    input wire [5:0] outSelIndex,
    input wire inSelWrite,
    input wire [4:0] inSelIndex,
    input wire [`PPSL_SEL_W-1:0] selData,
    input wire lockByteWrite,
    input wire [7:0] lockData,
    input wire lockBitSet,
    input wire lockBitClear,
    input wire [`PPSL_NPINS-1:0] portLatch,
    input wire [`PPSL_NPINS-1:0] pinDirIn,
    input wire [`PPSL_NSRC-1:0] periphOut,
    input wire [`PPSL_NSRC-1:0] periphOwnsDriver,
    input wire [`PPSL_NSRC-1:0] periphDriveEn,
    input wire [`PPSL_NPINS-1:0] pinIn,
    output wire [`PPSL_NPINS-1:0] pinOut,
    output wire [`PPSL_NPINS-1:0] pinOe,
    output wire [`PPSL_NPINS-1:0] portRead,
    output reg [`PPSL_NINSEL-1:0] periphIn,
    output wire [`PPSL_NPINS*`PPSL_SEL_W-1:0] outSelectors,
    output wire [`PPSL_NINSEL*`PPSL_SEL_W-1:0] inSelectors,
    output wire routingLockedFlag
);

    wire otherAccess;
    reg [`PPSL_SEL_W-1:0] outSel [0:`PPSL_NPINS-1];
    reg [`PPSL_SEL_W-1:0] inSel [0:`PPSL_NINSEL-1];
    reg [`PPSL_NPINS-1:0] sync1;
    reg [`PPSL_NPINS-1:0] sync2;
    reg [`PPSL_NPINS-1:0] sync3;
    reg [`PPSL_NPINS-1:0] pinLevel;
    integer k;
    integer m;

    function [`PPSL_SEL_W-1:0] inDefault;
        input integer idx;
        begin
            case (idx)
                0: inDefault = `PPSL_IN_DEF_0;
                1: inDefault = `PPSL_IN_DEF_1;
                2: inDefault = `PPSL_IN_DEF_2;
                3: inDefault = `PPSL_IN_DEF_3;
                4: inDefault = `PPSL_IN_DEF_4;
                5: inDefault = `PPSL_IN_DEF_5;
                6: inDefault = `PPSL_IN_DEF_6;
                7: inDefault = `PPSL_IN_DEF_7;
                8: inDefault = `PPSL_IN_DEF_8;
                9: inDefault = `PPSL_IN_DEF_9;
                10: inDefault = `PPSL_IN_DEF_10;
                11: inDefault = `PPSL_IN_DEF_11;
                12: inDefault = `PPSL_IN_DEF_12;
                13: inDefault = `PPSL_IN_DEF_13;
                14: inDefault = `PPSL_IN_DEF_14;
                15: inDefault = `PPSL_IN_DEF_15;
                16: inDefault = `PPSL_IN_DEF_16;
                17: inDefault = `PPSL_IN_DEF_17;
                18: inDefault = `PPSL_IN_DEF_18;
                19: inDefault = `PPSL_IN_DEF_19;
                20: inDefault = `PPSL_IN_DEF_20;
                21: inDefault = `PPSL_IN_DEF_21;
                22: inDefault = `PPSL_IN_DEF_22;
                23: inDefault = `PPSL_IN_DEF_23;
                24: inDefault = `PPSL_IN_DEF_24;
                25: inDefault = `PPSL_IN_DEF_25;
                26: inDefault = `PPSL_IN_DEF_26;
                27: inDefault = `PPSL_IN_DEF_27;
                28: inDefault = `PPSL_IN_DEF_28;
                29: inDefault = `PPSL_IN_DEF_29;
                default: inDefault = 5'h00;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Lock

    assign otherAccess = outSelWrite | inSelWrite;

    ppsl_lock u_lock (
        .clk(clk),
        .rstn(rstn),
        .deviceResetPulse(deviceResetPulse),
        .oneWayCfg(oneWayCfg),
        .lockByteWrite(lockByteWrite),
        .lockData(lockData),
        .lockBitSet(lockBitSet),
        .lockBitClear(lockBitClear),
        .otherAccess(otherAccess),
        .routingLockedFlag(routingLockedFlag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Selectors

    genvar g;
    generate
        for (g = 0; g < `PPSL_NPINS; g = g + 1) begin : gOutSel
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    outSel[g] <= `PPSL_OUTSEL_RESET;
                end else if (outSelWrite && !routingLockedFlag && outSelIndex == g) begin
                    outSel[g] <= selData;
                end
            end
            assign outSelectors[g*`PPSL_SEL_W +: `PPSL_SEL_W] = outSel[g];
        end
        for (g = 0; g < `PPSL_NINSEL; g = g + 1) begin : gInSel
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    inSel[g] <= inDefault(g);
                end else if (inSelWrite && !routingLockedFlag && inSelIndex == g) begin
                    inSel[g] <= selData;
                end
            end
            assign inSelectors[g*`PPSL_SEL_W +: `PPSL_SEL_W] = inSel[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    // Level taken only once the two later stages agree
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= {`PPSL_NPINS{1'b0}};
            sync2 <= {`PPSL_NPINS{1'b0}};
            sync3 <= {`PPSL_NPINS{1'b0}};
            pinLevel <= {`PPSL_NPINS{1'b0}};
        end else begin
            sync1 <= pinIn;
            sync2 <= sync1;
            sync3 <= sync2;
            for (k = 0; k < `PPSL_NPINS; k = k + 1) begin
                if (sync2[k] == sync3[k]) begin
                    pinLevel[k] <= sync3[k];
                end
            end
        end
    end

    assign portRead = pinLevel;

    ////////////////////////////////////////////////////////////////////////
    // Input routing

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periphIn <= {`PPSL_NINSEL{1'b0}};
        end else begin
            for (m = 0; m < `PPSL_NINSEL; m = m + 1) begin
                periphIn[m] <= pinLevel[{inSel[m][`PPSL_IN_PORT_HI:`PPSL_IN_PORT_LO],
                                         inSel[m][`PPSL_IN_PIN_HI:`PPSL_IN_PIN_LO]}];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output routing

    generate
        for (g = 0; g < `PPSL_NPINS; g = g + 1) begin : gOutMux
            ppsl_out_mux u_mux (
                .clk(clk),
                .rstn(rstn),
                .sel(outSel[g]),
                .latchBit(portLatch[g]),
                .dirIsInput(pinDirIn[g]),
                .src(periphOut),
                .ownsDriver(periphOwnsDriver),
                .driveEn(periphDriveEn),
                .pinOut(pinOut[g]),
                .pinOe(pinOe[g])
            );
        end
    endgenerate

endmodule

/* File: verif/ppsl_periph_model.sv */
// Partner model: the on-chip peripherals that feed the pin routing matrix.
// Assumes the bench pulses stepEn to move outputs; they hold otherwise.
`timescale 1ns/1ps
module ppsl_periph_model (
    input wire clk,
    input wire rstn,
    input wire stepEn,
    output reg [23:0] periphOut,
    output wire [23:0] periphOwnsDriver,
    output wire [23:0] periphDriveEn
);
    assign periphOwnsDriver = 24'h03cf00;
    // Rotated copy, so enable and data are not simply equal
    assign periphDriveEn = {periphOut[0], periphOut[23:1]};
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periphOut <= 24'h5a3c96;
        end else if (stepEn) begin
            periphOut <= {periphOut[22:0], periphOut[23] ^ periphOut[22] ^ periphOut[16]};
        end
    end
endmodule

/* File: verif/ppsl_top_sva.sv */
// Checker on the ports of ppsl_top: routing mux, selector writes and lock.
// Assumes one clock and rstn as the asynchronous power-on reset.
`timescale 1ns/1ps
module ppsl_top_sva (
    input wire clk,
    input wire rstn,
    input wire deviceResetPulse,
    input wire oneWayCfg,
    input wire outSelWrite,
    input wire [5:0] outSelIndex,
    input wire [4:0] selData,
    input wire lockByteWrite,
    input wire [7:0] lockData,
    input wire lockBitSet,
    input wire lockBitClear,
    input wire [39:0] portLatch,
    input wire [39:0] pinDirIn,
    input wire [23:0] periphOut,
    input wire [23:0] periphOwnsDriver,
    input wire [23:0] periphDriveEn,
    input wire [39:0] pinIn,
    input wire [39:0] pinOut,
    input wire [39:0] pinOe,
    input wire [39:0] portRead,
    input wire [199:0] outSelectors,
    input wire [149:0] inSelectors,
    input wire routingLockedFlag
);
    wire [4:0] sel5 = outSelectors[29:25];
    // Unused codes fall back to the latch
    wire useLatch = (sel5 == 5'h00) || (sel5 > 5'h17);
    wire [4:0] srcIdx = sel5 - 5'h01;
    wire expOut = useLatch ? portLatch[5] : periphOut[srcIdx];
    wire expOe = (useLatch || !periphOwnsDriver[srcIdx]) ? !pinDirIn[5] : periphDriveEn[srcIdx];
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    //////////////////////////////////////////////////////////////////////////////////////////
    pin_data_mux_a: assert property ($past(rstn) |-> pinOut[5] == $past(expOut))
        else $error("pin data differs from source");
    pin_drive_owner_a: assert property ($past(rstn) |-> pinOe[5] == $past(expOe))
        else $error("pin enable differs from owner");
    sel_write_take_a: assert property (
        outSelWrite && !routingLockedFlag && outSelIndex < 6'd40
        |=> outSelectors[$past(outSelIndex) * 5 +: 5] == $past(selData))
        else $error("selector write lost");
    lock_freeze_a: assert property (
        routingLockedFlag |=> $stable(outSelectors) && $stable(inSelectors))
        else $error("selector moved while locked");
    flag_cause_a: assert property (
        $changed(routingLockedFlag) |-> $past(lockBitSet || lockBitClear || deviceResetPulse))
        else $error("lock flag moved without bit op");
    key_then_set_a: assert property (
        lockByteWrite && lockData == 8'h55 ##1 lockByteWrite && lockData == 8'haa
        ##1 lockBitSet && !lockByteWrite && !deviceResetPulse && !oneWayCfg |=> routingLockedFlag)
        else $error("keyed set refused");
    dev_reset_clear_a: assert property (deviceResetPulse |=> !routingLockedFlag)
        else $error("lock kept over device reset");
    pin_read_level_a: assert property ($stable(pinIn)[*5] |=> portRead == $past(pinIn))
        else $error("port read differs from pin");
endmodule
bind ppsl_top ppsl_top_sva chk (.*);

/* File: verif/tb_top.sv */
// Bench for ppsl_top: integer model of selectors and lock, checked at each step.
// Assumes the partner drives peripheral outputs; pins are driven here.
`timescale 1ns/1ps
`include "ppsl_map.vh"
module tb_top;
    reg clk = 1'b0, rstn = 1'b0, deviceResetPulse = 1'b0, oneWayCfg = 1'b0, stepEn = 1'b0;
    reg outSelWrite = 1'b0, inSelWrite = 1'b0;
    reg lockByteWrite = 1'b0, lockBitSet = 1'b0, lockBitClear = 1'b0;
    reg [5:0] outSelIndex = 6'h00;
    reg [4:0] inSelIndex = 5'h00, selData = 5'h00;
    reg [7:0] lockData = 8'h00;
    reg [39:0] portLatch = 40'h0, pinDirIn = 40'h0, pinIn = 40'h0;
    wire [23:0] periphOut, periphOwnsDriver, periphDriveEn;
    wire [39:0] pinOut, pinOe, portRead;
    wire [29:0] periphIn;
    wire [199:0] outSelectors;
    wire [149:0] inSelectors;
    wire routingLockedFlag;
    integer outSel [0:39];
    integer error_cnt = 0, check_count = 0, lock, stage, setUsed, clrUsed, in0, i, v, p;
    ppsl_top dut (.*);
    ppsl_periph_model partner (.*);
    initial forever #5 clk = ~clk;
    //////////////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [199:0] got, input logic [199:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    task clearModel;
        begin
            lock = 0;
            stage = 0;
            setUsed = 0;
            clrUsed = 0;
        end
    endtask
    task por;
        begin
            @(posedge clk);
            rstn <= 1'b0;
            repeat (20) @(posedge clk);
            rstn <= 1'b1;
            for (i = 0; i < 40; i = i + 1) outSel[i] = 0;
            in0 = `PPSL_IN_DEF_0;
            clearModel;
        end
    endtask
    task devRst;
        begin
            @(posedge clk);
            deviceResetPulse <= 1'b1;
            @(posedge clk);
            deviceResetPulse <= 1'b0;
            clearModel;
        end
    endtask
    task wrSel(input integer isIn, input integer idx, input integer data);
        begin
            @(posedge clk);
            outSelWrite <= (isIn == 0);
            inSelWrite <= (isIn != 0);
            outSelIndex <= idx[5:0];
            inSelIndex <= idx[4:0];
            selData <= data[4:0];
            @(posedge clk);
            outSelWrite <= 1'b0;
            inSelWrite <= 1'b0;
            if (isIn == 0 && lock == 0 && idx < 40) outSel[idx] = data;
            if (isIn != 0 && lock == 0 && idx == 0) in0 = data;
            stage = 0;
        end
    endtask
    // Kind 0 byte, 1 bit set, 2 bit clear, 3 idle; strobe stays up until the next call
    task lockOp(input integer kind, input integer data);
        begin
            @(posedge clk);
            lockByteWrite <= (kind == 0);
            lockBitSet <= (kind == 1);
            lockBitClear <= (kind == 2);
            lockData <= data[7:0];
            if (kind == 0) begin
                stage = (data == 8'h55) ? 1 : ((data == 8'haa && stage == 1) ? 2 : 0);
            end else if (kind < 3) begin
                if (stage == 2 && kind == 1 && !(oneWayCfg && setUsed)) lock = 1;
                if (stage == 2 && kind == 2 && !(oneWayCfg && clrUsed)) lock = 0;
                if (stage == 2 && kind == 1) setUsed = 1;
                if (stage == 2 && kind == 2) clrUsed = 1;
                stage = 0;
            end
        end
    endtask
    // Back to back, so nothing else can slip between key and bit op
    task keyOp(input integer kind);
        begin
            lockOp(0, 8'h55);
            lockOp(0, 8'haa);
            lockOp(kind, 0);
            lockOp(3, 0);
        end
    endtask
    task checkState;
        reg [199:0] e;
        integer c;
        begin
            repeat (3) @(posedge clk);
            #1;
            for (i = 0; i < 40; i = i + 1) e[i * 5 +: 5] = outSel[i][4:0];
            c = outSel[5];
            chk(outSelectors, e);
            chk(inSelectors[4:0], in0[4:0]);
            chk(routingLockedFlag, lock[0]);
            chk(pinOut[5], (c == 0 || c > 23) ? portLatch[5] : periphOut[c - 1]);
            chk(pinOe[5], (c == 0 || c > 23 || !periphOwnsDriver[c - 1]) ?
                !pinDirIn[5] : periphDriveEn[c - 1]);
        end
    endtask
    //////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(32'hd60c6801);
        por;
        checkState;
        $display("test reset done");
        for (v = 0; v < 32; v = v + 1) begin
            @(posedge clk);
            portLatch <= {8'h00, $urandom};
            pinDirIn <= {8'h00, $urandom};
            stepEn <= 1'b1;
            @(posedge clk);
            stepEn <= 1'b0;
            wrSel(0, 5, v);
            checkState;
        end
        $display("test code sweep done");
        for (p = 0; p < 6; p = p + 1) begin
            v = $urandom % 32;
            wrSel(1, 0, v);
            // output routed to the input pin
            wrSel(0, v, 5'h0f);
            @(posedge clk);
            pinIn <= {8'h00, $urandom};
            repeat (7) @(posedge clk);
            #1;
            chk(portRead, pinIn);
            chk(periphIn[0], pinIn[v]);
            chk(pinOut[v], periphOut[14]);
            chk(pinOe[v], periphDriveEn[14]);
        end
        $display("test input route done");
        // no other access inside the key
        keyOp(1);
        wrSel(0, 5, 3);
        wrSel(1, 0, 7);
        checkState;
        lockOp(0, 8'h00);
        lockOp(2, 0);
        lockOp(3, 0);
        checkState;
        lockOp(0, 8'h55);
        lockOp(0, 8'haa);
        lockOp(0, 8'h00);
        lockOp(2, 0);
        lockOp(3, 0);
        checkState;
        keyOp(2);
        checkState;
        $display("test lock done");
        @(posedge clk);
        oneWayCfg <= 1'b1;
        devRst;
        keyOp(2);
        keyOp(1);
        keyOp(2);
        wrSel(0, 5, 1);
        checkState;
        devRst;
        checkState;
        por;
        checkState;
        $display("test one-way and reset done");
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: run too long", $time);
        report_and_stop;
    end
endmodule
